//--- host_model.sv
`timescale 1ns/1ps
// host side: serial command pulses and board pin levels
module host_model
(
	input  wire logic   sys_clk,
	output logic [7:0]  pl,
	output logic [33:0] dv,
	output logic [5:0]  lvl
);
	// idle: no requests, test pin held low at power-up
	initial
	begin
		pl = 8'h00;
		dv = 34'h0;
		lvl = 6'h00;
	end
	////////////////////////////////////////
	// one-cycle request, launched on the falling edge
	task pulse(input logic [7:0] pv, input logic [33:0] dvv);
		@(negedge sys_clk);
		pl = pv;
		dv = dvv;
		@(negedge sys_clk);
		pl = 8'h00;
		dv = 34'h0;
	endtask : pulse
	// pin levels: test, supply en, bus wake, wake, cyclic[1:0]
	task lv(input logic [5:0] v);
		@(negedge sys_clk);
		lvl = v;
	endtask : lv
	// start-up order of the host
	task boot();
		pulse(8'h03, 34'h0);
		pulse(8'h84, 34'h0);
		pulse(8'h08, 34'h0);
	endtask : boot
endmodule : host_model

//--- sbc_mode_pkg.sv
package sbc_mode_pkg;
	// operating modes of the sequencer
	typedef enum logic [2:0]
	{
		mode_init,
		mode_normal,
		mode_stop,
		mode_sleep,
		mode_restart
	} sbc_mode_t;
	// watchdog flavours
	typedef enum logic
	{
		wd_timeout,
		wd_window
	} wd_mode_t;
endpackage : sbc_mode_pkg

//--- sbc_mode_regs.svh
// Overview of operation
// - power-on reset starts in init mode
// - any valid serial command moves init to normal
// - no command: flag watchdog failure after 200ms
// - watchdog defaults to time-out mode after power-up
// - refuse sleep while any wake flag set
// - pending wake flags: restart then normal
// - cyclic timer wake sets sticky timer flag
// - test pin low at power-up: development mode
// - bus wake works without secondary supply output
`ifndef SBC_MODE_REGS_SVH
`define SBC_MODE_REGS_SVH
`define CLK_FREQ_HZ        25000000
`define LONG_OPEN_MS       200
`define LONG_OPEN_CYCLES   ((`CLK_FREQ_HZ / 1000) * `LONG_OPEN_MS)
`define RESTART_CYCLES     4
`define WAKE_FIRST_W       8
`define WAKE_SECOND_W      8
`define TIMER_WAKE_BIT     0
`define WD_MODE_RESET      1'b0
`endif

//--- sbc_mode_sequencer.sv
`timescale 1ns/1ps
`include "sbc_mode_regs.svh"
module sbc_mode_sequencer
#(
	parameter int LONG_OPEN_CYCLES = `LONG_OPEN_CYCLES
)
(
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	input  wire logic                      cmd_valid,
	input  wire logic                      wd_trigger,
	input  wire logic                      wd_mode_wr,
	input  wire logic                      wd_mode_sel,
	input  wire logic                      por_flag_clr,
	input  wire logic                      stop_req,
	input  wire logic                      sleep_req,
	input  wire logic                      wake_event,
	input  wire logic [1:0]                timer_cyclic_en,
	input  wire logic [1:0]                timer_expire,
	input  wire logic                      timer_wake_clr,
	input  wire logic [`WAKE_FIRST_W-1:0]  wake_first_set,
	input  wire logic [`WAKE_FIRST_W-1:0]  wake_first_clr,
	input  wire logic [`WAKE_SECOND_W-1:0] wake_second_set,
	input  wire logic [`WAKE_SECOND_W-1:0] wake_second_clr,
	input  wire logic                      bus_wake_pin,
	input  wire logic                      test_pin_n,
	input  wire logic                      secondary_supply_en,
	output sbc_mode_pkg::sbc_mode_t        mode,
	output sbc_mode_pkg::wd_mode_t         wd_mode,
	output logic                           wd_fail,
	output logic                           por_flag,
	output logic                           dev_mode,
	output logic                           secondary_supply_output,
	output logic [`WAKE_FIRST_W-1:0]       wake_status_first,
	output logic [`WAKE_SECOND_W-1:0]      wake_status_second
);
	import sbc_mode_pkg::*;

	////////////////////////////////////////////////////////////////
	// pin synchronisers and timer wake gate
	////////////////////////////////////////////////////////////////
	logic [2:0] test_sync_r;  // test pin three-stage chain
	logic [2:0] bus_sync_r;   // bus wake three-stage chain
	logic       bus_wake;     // agreed bus wake level
	logic       test_low;     // agreed test pin low
	wake_timer_if wt ();
	assign wt.cyclic_en = timer_cyclic_en;
	assign wt.expire    = timer_expire;
	wake_timer_gate u_gate (.wt(wt));

	// shift pins in, stage one read only by stage two
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_sync_r  <= 3'h0;
		end
		else
		begin
			bus_sync_r  <= {bus_sync_r[1:0], bus_wake_pin};
		end
	end
	// strap chain runs through reset, so the pin level is
	// settled in all three stages when the window samples it
	always_ff @(posedge sys_clk)
		test_sync_r <= {test_sync_r[1:0], test_pin_n};
	assign test_low = ~test_sync_r[1] & ~test_sync_r[2];
	assign bus_wake = bus_sync_r[1] & bus_sync_r[2];

	////////////////////////////////////////////////////////////////
	// mode sequencer and flags
	////////////////////////////////////////////////////////////////
	sbc_mode_t                  mode_r, mode_nxt;
	wd_mode_t                   wdm_r, wdm_nxt;
	logic [31:0]                cnt_r, cnt_nxt;     // long open count
	logic [2:0]                 rst_r, rst_nxt;     // restart dwell
	logic                       fail_r, fail_nxt;
	logic                       por_r, por_nxt;
	logic                       dev_r, dev_nxt;
	logic [1:0]                 pu_r, pu_nxt;       // power-up sample window
	logic                       ss_r, ss_nxt;
	logic [`WAKE_FIRST_W-1:0]   wf_r, wf_nxt;
	logic [`WAKE_SECOND_W-1:0]  ws_r, ws_nxt;
	logic                       any_wake;

	// wake flags pending in either status register
	assign any_wake = (|wf_r) | (|ws_r);

	// next state computation
	always_comb
	begin
		mode_nxt = mode_r;
		wdm_nxt  = wdm_r;
		cnt_nxt  = cnt_r;
		rst_nxt  = rst_r;
		fail_nxt = fail_r;
		por_nxt  = por_r;
		dev_nxt  = dev_r;
		pu_nxt   = pu_r;
		ss_nxt   = secondary_supply_en;
		wf_nxt = (wf_r & ~wake_first_clr) | wake_first_set;
		ws_nxt = (ws_r & ~wake_second_clr) | wake_second_set;
		if (timer_wake_clr)
			ws_nxt[`TIMER_WAKE_BIT] = 1'b0;
		if (wt.event_hit)
			ws_nxt[`TIMER_WAKE_BIT] = 1'b1;
		// clear by write, set wins at reset only
		if (por_flag_clr)
			por_nxt = 1'b0;
		if (pu_r != 2'h3)
		begin
			pu_nxt = pu_r + 2'h1;
			if (pu_r == 2'h2)
				dev_nxt = test_low;
		end
		if (wd_mode_wr)
			wdm_nxt = wd_mode_t'(wd_mode_sel);
		case (mode_r)
			mode_init:
			begin
				if (cmd_valid)
				begin
					mode_nxt = mode_normal;
					cnt_nxt  = 32'h0;
				end
				else if (cnt_r >= LONG_OPEN_CYCLES - 1)
					fail_nxt = 1'b1;
				else
					cnt_nxt = cnt_r + 32'h1;
			end
			mode_normal:
			begin
				if (wd_trigger)
					fail_nxt = 1'b0;
				if (sleep_req && any_wake)
				begin
					mode_nxt = mode_restart;
					rst_nxt  = 3'h0;
				end
				else if (sleep_req)
					mode_nxt = mode_sleep;
				else if (stop_req)
					mode_nxt = mode_stop;
			end
			mode_stop, mode_sleep:
			begin
				if (bus_wake || wake_event || any_wake)
				begin
					mode_nxt = mode_restart;
					rst_nxt  = 3'h0;
				end
			end
			mode_restart:
			begin
				if (rst_r == 3'(`RESTART_CYCLES - 1))
					mode_nxt = mode_normal;
				else
					rst_nxt = rst_r + 3'h1;
			end
			default: mode_nxt = mode_init;
		endcase
	end

	// register stage
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_r <= mode_init;
			wdm_r  <= wd_timeout;
			cnt_r  <= 32'h0;
			rst_r  <= 3'h0;
			fail_r <= 1'b0;
			por_r  <= 1'b1;
			dev_r  <= 1'b0;
			pu_r   <= 2'h0;
			ss_r   <= 1'b0;
			wf_r   <= '0;
			ws_r   <= '0;
		end
		else
		begin
			mode_r <= mode_nxt;
			wdm_r  <= wdm_nxt;
			cnt_r  <= cnt_nxt;
			rst_r  <= rst_nxt;
			fail_r <= fail_nxt;
			por_r  <= por_nxt;
			dev_r  <= dev_nxt;
			pu_r   <= pu_nxt;
			ss_r   <= ss_nxt;
			wf_r   <= wf_nxt;
			ws_r   <= ws_nxt;
		end
	end

	assign mode                    = mode_r;
	assign wd_mode                 = wdm_r;
	assign wd_fail                 = fail_r;
	assign por_flag                = por_r;
	assign dev_mode                = dev_r;
	assign secondary_supply_output = ss_r;
	assign wake_status_first       = wf_r;
	assign wake_status_second      = ws_r;

	////////////////////////////////////////////////////////////////
	// assertions
	////////////////////////////////////////////////////////////////
	property p_init_exit;
		@(posedge sys_clk) disable iff (!rstn)
		(mode_r == mode_init && cmd_valid) |=> (mode_r == mode_normal);
	endproperty
	a_init_exit: assert property (p_init_exit)
		else $error("init did not leave on command");

	property p_no_sleep;
		@(posedge sys_clk) disable iff (!rstn)
		(mode_r == mode_normal && sleep_req && any_wake)
		|=> (mode_r == mode_restart);
	endproperty
	a_no_sleep: assert property (p_no_sleep)
		else $error("sleep entered with wake pending");

	property p_restart_out;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(mode_r == mode_restart) |-> ##4 (mode_r == mode_normal);
	endproperty
	a_restart_out: assert property (p_restart_out)
		else $error("restart did not reach normal");

	property p_timer_flag;
		@(posedge sys_clk) disable iff (!rstn)
		wt.event_hit |=> ws_r[`TIMER_WAKE_BIT];
	endproperty
	a_timer_flag: assert property (p_timer_flag)
		else $error("timer wake flag not set");

	property p_timer_hold;
		@(posedge sys_clk) disable iff (!rstn)
		(ws_r[`TIMER_WAKE_BIT] && !timer_wake_clr
		 && !wake_second_clr[`TIMER_WAKE_BIT]) |=> ws_r[`TIMER_WAKE_BIT];
	endproperty
	a_timer_hold: assert property (p_timer_hold)
		else $error("timer wake flag dropped");

	property p_fail_init;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(fail_r) |-> (mode_r == mode_init);
	endproperty
	a_fail_init: assert property (p_fail_init)
		else $error("watchdog failure outside init");

	property p_wd_mode;
		@(posedge sys_clk) disable iff (!rstn)
		$changed(wdm_r) |-> $past(wd_mode_wr);
	endproperty
	a_wd_mode: assert property (p_wd_mode)
		else $error("watchdog mode changed unasked");

	property p_por_hold;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(por_r) |-> $past(por_flag_clr);
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("power-on flag cleared without write");

	property p_dev_keep;
		@(posedge sys_clk) disable iff (!rstn)
		(pu_r == 2'h3) |=> $stable(dev_r);
	endproperty
	a_dev_keep: assert property (p_dev_keep)
		else $error("development mode changed after power-up");

	property p_first_mode;
		@(posedge sys_clk) disable iff (!rstn)
		(pu_r == 2'h0) |-> (mode_r == mode_init);
	endproperty
	a_first_mode: assert property (p_first_mode)
		else $error("did not start in init");

	c_init_exit: cover property (@(posedge sys_clk) disable iff (!rstn)
		mode_r == mode_init ##1 mode_r == mode_normal);
	c_refused: cover property (@(posedge sys_clk) disable iff (!rstn)
		mode_r == mode_normal && sleep_req && any_wake);
	c_sleep: cover property (@(posedge sys_clk) disable iff (!rstn)
		mode_r == mode_sleep);
endmodule : sbc_mode_sequencer

//--- sbc_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
// mode sequencer bench: notes queued, monitor compares
module sbc_mode_sequencer_tb_top;
	import sbc_mode_pkg::*;
	typedef struct packed {logic [3:0] id; logic [7:0] ex;} note_t;
	logic              sys_clk;   // 25 MHz
	logic              rstn;      // power-on reset
	logic [7:0]        pl;        // request pulses
	logic [33:0]       dv;        // flag set/clear, expiry
	logic [5:0]        lvl;       // pin levels
	sbc_mode_t         mode;
	wd_mode_t          wd_mode;
	logic              wd_fail;
	logic              por_flag;
	logic              dev_mode;
	logic              sso;
	logic [7:0]        ws1;
	logic [7:0]        ws2;
	logic [31:0]       rnd;
	logic [1:0]        tb;        // enabled timer
	note_t             notes[$];  // expected results
	note_t             n;
	event              note_ev;
	int                n_errors = 0;
	int                n_checks = 0;
	int                cyc = 0;
	host_model host (.sys_clk(sys_clk), .pl(pl), .dv(dv), .lvl(lvl));
	sbc_mode_sequencer #(.LONG_OPEN_CYCLES(50)) DUT
	(
		.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(pl[0]),
		.wd_trigger(pl[1]), .wd_mode_wr(pl[2]), .wd_mode_sel(pl[7]),
		.por_flag_clr(pl[3]), .stop_req(pl[4]), .sleep_req(pl[5]),
		.wake_event(lvl[2]), .timer_cyclic_en(lvl[1:0]),
		.timer_expire(dv[1:0]), .timer_wake_clr(pl[6]),
		.wake_first_set(dv[33:26]), .wake_first_clr(dv[25:18]),
		.wake_second_set(dv[17:10]), .wake_second_clr(dv[9:2]),
		.bus_wake_pin(lvl[3]), .test_pin_n(lvl[5]),
		.secondary_supply_en(lvl[4]), .mode(mode), .wd_mode(wd_mode),
		.wd_fail(wd_fail), .por_flag(por_flag), .dev_mode(dev_mode),
		.secondary_supply_output(sso), .wake_status_first(ws1),
		.wake_status_second(ws2)
	);
	////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			n_errors++;
			final_report();
		end
	end
	// observed value by note id
	function logic [7:0] obs(input logic [3:0] id);
		case (id)
			0: obs = {5'h00, mode};
			1: obs = {7'h00, wd_mode};
			2: obs = {7'h00, wd_fail};
			3: obs = {7'h00, por_flag};
			4: obs = {7'h00, dev_mode};
			5: obs = ws1;
			6: obs = ws2;
			7: obs = {7'h00, sso};
			8: obs = {7'h00, mode === mode_sleep};
			default: obs = {7'h00, mode === mode_stop};
		endcase
	endfunction : obs
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task ex(input logic [3:0] id, input logic [7:0] v);
		notes.push_back('{id, v});
		->note_ev;
	endtask : ex
	task wt(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : wt
	task final_report();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// monitor: oldest note against the outputs
	initial
	forever
	begin
		@(note_ev);
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			check(obs(n.id), n.ex);
		end
	end
	////////////////////////////////////////
	// main sequence
	initial
	begin
		rstn = 1'b0;
		void'($urandom(63));
		rnd = $urandom;
		tb = rnd[8] ? 2'b10 : 2'b01;
		wt(2);
		rstn = 1'b1;
		wt(6);
		host.lv(6'h20);
		wt(2);
		ex(0, {5'h00, mode_init});
		ex(1, {7'h00, wd_timeout});
		ex(3, 8'h01);
		ex(4, 8'h01);
		ex(2, 8'h00);
		wt(50);
		ex(2, 8'h01);
		ex(0, {5'h00, mode_init});
		host.boot();
		wt(1);
		ex(0, {5'h00, mode_normal});
		ex(1, {7'h00, wd_window});
		ex(3, 8'h00);
		host.pulse(8'h02, 34'h0);
		wt(1);
		ex(2, 8'h00);
		// expiry of the disabled timer must not flag
		host.lv({4'b1100, tb});
		host.pulse(8'h00, {32'h0, ~tb});
		wt(1);
		ex(6, 8'h00);
		host.pulse(8'h00, {rnd[7:0] | 8'h01, 24'h0, tb});
		wt(1);
		ex(6, 8'h01);
		ex(5, rnd[7:0] | 8'h01);
		ex(7, 8'h01);
		wt(5);
		ex(6, 8'h01);
		// sleep refused while flags pending
		host.pulse(8'h20, 34'h0);
		wt(1);
		ex(0, {5'h00, mode_restart});
		ex(8, 8'h00);
		wt(6);
		ex(0, {5'h00, mode_normal});
		host.pulse(8'h40, {8'h00, 8'hff, 8'h00, 8'hff, 2'b00});
		wt(1);
		ex(5, 8'h00);
		ex(6, 8'h00);
		host.pulse(8'h20, 34'h0);
		wt(1);
		ex(8, 8'h01);
		// bus wake with the secondary output off
		host.lv({4'b1010, tb});
		wt(8);
		ex(8, 8'h00);
		ex(7, 8'h00);
		host.lv({4'b1000, tb});
		wt(8);
		host.pulse(8'h10, 34'h0);
		wt(1);
		ex(9, 8'h01);
		host.lv({4'b1001, tb});
		wt(8);
		ex(9, 8'h00);
		host.lv({4'b1000, tb});
		// second power-on in mid-run, test pin high
		wt(4);
		rstn = 1'b0;
		wt(2);
		rstn = 1'b1;
		wt(5);
		ex(0, {5'h00, mode_init});
		ex(3, 8'h01);
		ex(4, 8'h00);
		ex(1, {7'h00, wd_timeout});
		wt(1);
		final_report();
	end
endmodule : sbc_mode_sequencer_tb_top

//--- wake_timer_gate.sv
`timescale 1ns/1ps
module wake_timer_gate
(
	wake_timer_if.timer wt
);
	logic [1:0] hit;  // per timer qualified expiry
	genvar g;
	// qualify each timer with its cyclic mode
	generate
		for (g = 0; g < 2; g++)
		begin : g_tim
			assign hit[g] = wt.expire[g] & wt.cyclic_en[g];
		end
	endgenerate
	assign wt.event_hit = |hit;
endmodule : wake_timer_gate

//--- wake_timer_if.sv
`timescale 1ns/1ps
// timer wake event path between sequencer and timer block
interface wake_timer_if;
	logic [1:0] cyclic_en;  // per timer cyclic wake enable
	logic [1:0] expire;     // per timer expiry pulse
	logic       event_hit;  // any enabled cyclic expiry
	modport seq   (output cyclic_en, output expire, input event_hit);
	modport timer (input cyclic_en, input expire, output event_hit);
endinterface : wake_timer_if
